/* File: core/frx_pkg.sv */
// Shared constants for the receive status and counter register group
package frx_pkg;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int CODE_RESET_US = 250;
	localparam int CODE_RESET_CYCLES = CODE_RESET_US * 1000000 / CLK_PERIOD_PS;
	localparam int CNT_WIDTH = 16;
	localparam int SEARCH_WIDTH = 6;
	localparam int SF_FS_BITS = 6;
	localparam logic [7:0] IDX_SIG_FIRST = 8'h40;
	localparam logic [7:0] IDX_SIG_LAST = 8'h4F;
	localparam logic [7:0] IDX_LINE_HI = 8'h50;
	localparam logic [7:0] IDX_LINE_LO = 8'h51;
	localparam logic [7:0] IDX_PATH_HI = 8'h52;
	localparam logic [7:0] IDX_PATH_LO = 8'h53;
	localparam logic [7:0] IDX_SYNC_HI = 8'h54;
	localparam logic [7:0] IDX_SYNC_LO = 8'h55;
	localparam logic [7:0] IDX_FAR_HI = 8'h56;
	localparam logic [7:0] IDX_FAR_LO = 8'h57;
	localparam logic [7:0] IDX_MONITOR = 8'h60;
	localparam logic [7:0] IDX_FW_REV = 8'h61;
	localparam logic [7:0] IDX_LINK = 8'h62;
	localparam logic [7:0] IDX_CODE = 8'h63;
	localparam logic [7:0] IDX_SLC1 = 8'h64;
	localparam logic [7:0] IDX_SLC2 = 8'h65;
	localparam logic [7:0] IDX_SLC3 = 8'h66;
	localparam logic [7:0] IDX_CFG = 8'h70;
	localparam logic [7:0] IDX_MON_SEL = 8'h71;
	localparam logic [7:0] IDX_CODE_CTRL = 8'h72;
	localparam int CFG_E1_BIT = 0;
	localparam int CFG_ESF_BIT = 1;
	localparam int CFG_CRC_BIT = 3;
	localparam int CODE_RESET_BIT = 7;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [4:0] MON_SEL_RESET = 5'h00;
	localparam logic [3:0] FILTER_RESET = 4'h0;
	localparam logic [7:0] FW_REV_DEFAULT = 8'h01;
endpackage

/* File: core/frx_event_counter.sv */
// Event counter with clear and optional saturation
module frx_event_counter
	import frx_pkg::*;
#(
	parameter int WIDTH = CNT_WIDTH,
	parameter bit SATURATE = 1'b1
)
(
	input wire logic clk,
	input wire logic rstN,
	input wire logic inc,
	input wire logic clear,
	output logic [WIDTH-1:0] count
);
	typedef struct packed {
		logic [WIDTH-1:0] cnt;
	} frx_cnt_t;

	frx_cnt_t st_reg;
	frx_cnt_t st_next;

	always_comb
	begin
		st_next = st_reg;
		if (clear)
			st_next.cnt = '0;
		else if (inc && !(SATURATE && (&st_reg.cnt)))
			st_next.cnt = st_reg.cnt + 1'b1;
	end

	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign count = st_reg.cnt;

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstN);

	property p_cnt_saturate;
		SATURATE && inc && !clear && (&count) |=> (&count);
	endproperty
	a_cnt_saturate: assert property (p_cnt_saturate) else $error("counter wrapped");

	property p_cnt_clear;
		clear |=> count == '0;
	endproperty
	a_cnt_clear: assert property (p_cnt_clear) else $error("counter not cleared");
endmodule

/* File: core/frx_code_reset.sv */
// Self-clearing reset of the code detector with deferred filter settings
module frx_code_reset
	import frx_pkg::*;
#(
	parameter int CYCLES = CODE_RESET_CYCLES
)
(
	input wire logic clk,
	input wire logic rstN,
	input wire logic start,
	input wire logic [3:0] filterPending,
	output logic busy,
	output logic [3:0] filterApplied
);
	localparam int CW = $clog2(CYCLES + 1);

	typedef enum logic [0:0] {
		CR_IDLE = 1'b0,
		CR_RUN = 1'b1
	} frx_cr_state_t;

	typedef struct packed {
		frx_cr_state_t state;
		logic [CW-1:0] cnt;
		logic [3:0] filter;
	} frx_cr_t;

	frx_cr_t st_reg;
	frx_cr_t st_next;

	always_comb
	begin
		st_next = st_reg;
		case (st_reg.state)
			CR_IDLE:
			begin
				if (start)
				begin
					st_next.state = CR_RUN;
					st_next.cnt = CW'(CYCLES - 1);
				end
			end
			CR_RUN:
			begin
				if (st_reg.cnt == '0)
				begin
					st_next.state = CR_IDLE;
					st_next.filter = filterPending;
				end
				else
					st_next.cnt = st_reg.cnt - 1'b1;
			end
			default: st_next.state = CR_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			st_reg <= '{state: CR_IDLE, cnt: '0, filter: FILTER_RESET};
		else
			st_reg <= st_next;
	end

	assign busy = (st_reg.state == CR_RUN);
	assign filterApplied = st_reg.filter;

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstN);

	property p_cr_bound;
		busy |-> st_reg.cnt < CW'(CYCLES);
	endproperty
	a_cr_bound: assert property (p_cr_bound) else $error("code reset overran");

	property p_cr_hold;
		busy |=> $stable(filterApplied) || !busy;
	endproperty
	a_cr_hold: assert property (p_cr_hold) else $error("filter applied early");

	c_cr_done: cover property (busy ##1 !busy);
endmodule

/* File: core/frx_status_counters.sv */
// Receive status and performance counter register group, APB slave
// What this block does
// - Extended superframe keeps four signaling bits per channel, superframe only A and B.
// - In superframe mode received A and B are copied into C and D.
// - Signaling registers freeze while frame sync is lost.
// - Line error count is 16 bits, upper byte at lower address.
// - Path error count is 16 bits, upper then lower byte.
// - Sync loss frame count is 16 bits, upper byte first.
// - Far error count runs in E1 only, upper byte first.
// - Selected timeslot byte shown with first received bit at bit 7.
// - E1 mode reads a fixed firmware revision byte.
// - Shared address is link byte in T1, real-time sync status in E1.
// - Search counter counts search timeouts, clears on CRC level sync.
// - Writing the CRC mode enable bit to zero clears the search counter.
// - Search counter is 6 bits, saturates; bits 5..2 and 0 visible.
// - Bits 2..0 flag CRC, signaling and frame alignment searches.
// - Last validated 6-bit code sits in bits 5..0, upper bits zero.
// - Link byte carries link or Fs bits, first received in bit 0.
// - Superframe link byte loads six Fs bits at multiframe boundaries.
// - T1 three registers show loop carrier link fields.
// - E1 first of them shows the align frame byte.
// - Code logic reset self clears within 250us; filters apply afterwards.
//
// Decided for this implementation: the APB interface to the registers.
module frx_status_counters
	import frx_pkg::*;
#(
	parameter int CODE_RESET_CNT = CODE_RESET_CYCLES,
	parameter logic [7:0] FW_REV = FW_REV_DEFAULT // Arbitrary value
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic frameSyncLost,
	input wire logic sigValid,
	input wire logic [4:0] sigChannel,
	input wire logic [3:0] sigBits,
	input wire logic lineErrEvent,
	input wire logic pathErrEvent,
	input wire logic syncLossFrameEvent,
	input wire logic farErrorEvent,
	input wire logic slotValid,
	input wire logic [4:0] slotNumber,
	input wire logic [7:0] slotByte,
	input wire logic linkBitValid,
	input wire logic linkBit,
	input wire logic mfBoundary,
	input wire logic crcSearchTimeout,
	input wire logic crcSyncAchieved,
	input wire logic crcMfSearching,
	input wire logic signalingMfSearching,
	input wire logic frameAlignSearching,
	input wire logic codeValid,
	input wire logic [5:0] codeWord,
	input wire logic slcValid,
	input wire logic [23:0] slcBits,
	input wire logic alignValid,
	input wire logic [7:0] alignByte,
	output logic e1Mode,
	output logic esfMode,
	output logic crcModeEnable,
	output logic [4:0] monitorChannelSelect,
	output logic codeLogicReset,
	output logic [3:0] codeFilterSetting
);
	typedef struct packed {
		logic [7:0] cfg;
		logic [4:0] monSel;
		logic [3:0] filter;
		logic [5:0] rxCodeWord;
		logic [7:0] monByte;
		logic [7:0] rxLinkByte;
		logic [7:0] linkShift;
		logic [2:0] linkCnt;
		logic [23:0] slc;
		logic [7:0] align;
		logic [15:0][7:0] sig;
		logic [31:0] rdata;
	} frx_state_t;

	frx_state_t st_reg;
	frx_state_t st_next;
	logic [1:0] rstSync_reg;
	logic rstN;
	logic [15:0] lineCount;
	logic [15:0] pathCount;
	logic [15:0] syncCount;
	logic [15:0] farCount;
	logic [5:0] searchCount;
	logic wrAccess;
	logic rdSetup;
	logic [7:0] idx;
	logic mapped;
	logic searchClear;
	logic codeStart;
	logic [3:0] sigNibble;
	logic [4:0] sigPos;
	logic [7:0] linkTmp;

	////////////////////////////////////////////////////////////////
	// Reset release through two flops
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rstSync_reg <= 2'b00;
		else
			rstSync_reg <= {rstSync_reg[0], 1'b1};
	end
	assign rstN = rstSync_reg[1];

	// Register index and nibble half for a signaling channel
	function automatic logic [4:0] sig_pos(input logic e1, input logic [4:0] ch);
		logic [4:0] p;
		p = 5'h00;
		if (e1)
			p = (ch <= 5'd15) ? {ch[3:0], 1'b1} : {4'(ch - 5'd15), 1'b0};
		else
			p = (ch <= 5'd12) ? {4'(ch - 5'd1), 1'b1} : {4'(ch - 5'd13), 1'b0};
		return p;
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		return (a >= IDX_SIG_FIRST && a <= IDX_FAR_LO)
			|| (a >= IDX_MONITOR && a <= IDX_SLC3)
			|| (a >= IDX_CFG && a <= IDX_CODE_CTRL);
	endfunction

	////////////////////////////////////////////////////////////////
	// APB decode; zero wait states
	assign idx = paddr[9:2];
	assign mapped = is_mapped(idx) && paddr[11:10] == 2'b00;
	assign wrAccess = psel && penable && pwrite && mapped;
	assign rdSetup = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign searchClear = crcSyncAchieved
		|| (wrAccess && idx == IDX_CFG && !pwdata[CFG_CRC_BIT]);
	assign codeStart = wrAccess && idx == IDX_CODE_CTRL && pwdata[CODE_RESET_BIT]
		&& !codeLogicReset;

	////////////////////////////////////////////////////////////////
	// Counters; host writes never reach them, except a CFG write with the CRC bit zero, which clears the search counter
	frx_event_counter #(.WIDTH(CNT_WIDTH), .SATURATE(1'b1)) u_line (
		.clk(clk), .rstN(rstN), .inc(lineErrEvent), .clear(1'b0),
		.count(lineCount));
	frx_event_counter #(.WIDTH(CNT_WIDTH), .SATURATE(1'b1)) u_path (
		.clk(clk), .rstN(rstN), .inc(pathErrEvent), .clear(1'b0), .count(pathCount));
	frx_event_counter #(.WIDTH(CNT_WIDTH), .SATURATE(1'b1)) u_sync (
		.clk(clk), .rstN(rstN), .inc(syncLossFrameEvent), .clear(1'b0),
		.count(syncCount));
	frx_event_counter #(.WIDTH(CNT_WIDTH), .SATURATE(1'b1)) u_far (
		.clk(clk), .rstN(rstN), .inc(farErrorEvent && e1Mode), .clear(1'b0),
		.count(farCount));
	frx_event_counter #(.WIDTH(SEARCH_WIDTH), .SATURATE(1'b1)) u_search (
		.clk(clk), .rstN(rstN), .inc(crcSearchTimeout && crcModeEnable),
		.clear(searchClear), .count(searchCount));

	frx_code_reset #(.CYCLES(CODE_RESET_CNT)) u_code_reset (
		.clk(clk),
		.rstN(rstN),
		.start(codeStart),
		.filterPending(st_reg.filter),
		.busy(codeLogicReset),
		.filterApplied(codeFilterSetting)
	);

	assign e1Mode = st_reg.cfg[CFG_E1_BIT];
	assign esfMode = st_reg.cfg[CFG_ESF_BIT];
	assign crcModeEnable = st_reg.cfg[CFG_CRC_BIT];
	assign monitorChannelSelect = st_reg.monSel;
	assign prdata = st_reg.rdata;

	////////////////////////////////////////////////////////////////
	always_comb
	begin
		st_next = st_reg;
		// Signaling capture, superframe copies A/B into C/D
		sigNibble = (!e1Mode && !esfMode)
			? {sigBits[3:2], sigBits[3:2]} : sigBits;
		sigPos = sig_pos(e1Mode, sigChannel);
		if (sigValid && !frameSyncLost)
		begin
			if (sigPos[0])
				st_next.sig[sigPos[4:1]][7:4] = sigNibble;
			else
				st_next.sig[sigPos[4:1]][3:0] = sigNibble;
		end
		if (slotValid && slotNumber == st_reg.monSel)
			st_next.monByte = slotByte;
		// Link bits: first received lands in bit 0
		linkTmp = st_reg.linkShift;
		if (linkBitValid)
		begin
			linkTmp[st_reg.linkCnt] = linkBit;
			st_next.linkShift = linkTmp;
			st_next.linkCnt = st_reg.linkCnt + 3'd1;
			if (esfMode && st_reg.linkCnt == 3'd7)
				st_next.rxLinkByte = linkTmp;
		end
		if (!esfMode && mfBoundary)
		begin
			st_next.rxLinkByte = {2'b00, linkTmp[SF_FS_BITS-1:0]};
			st_next.linkCnt = 3'd0;
		end
		if (codeLogicReset)
			st_next.rxCodeWord = 6'h00;
		else if (codeValid)
			st_next.rxCodeWord = codeWord;
		if (slcValid)
			st_next.slc = slcBits;
		if (alignValid)
			st_next.align = alignByte;
		// Host writes: only control registers are writable
		if (wrAccess)
		begin
			case (idx)
				IDX_CFG: st_next.cfg = pwdata[7:0] & 8'h0B;
				IDX_MON_SEL: st_next.monSel = pwdata[4:0];
				IDX_CODE_CTRL: st_next.filter = {pwdata[5:4], pwdata[2:1]};
				default: st_next.cfg = st_reg.cfg;
			endcase
		end
		// Read data sampled in the setup cycle
		if (rdSetup)
		begin
			st_next.rdata = 32'h0000_0000;
			if (idx >= IDX_SIG_FIRST && idx <= IDX_SIG_LAST)
				st_next.rdata[7:0] = st_reg.sig[idx[3:0]];
			else
			begin
				case (idx)
					IDX_LINE_HI: st_next.rdata[7:0] = lineCount[15:8];
					IDX_LINE_LO: st_next.rdata[7:0] = lineCount[7:0];
					IDX_PATH_HI: st_next.rdata[7:0] = pathCount[15:8];
					IDX_PATH_LO: st_next.rdata[7:0] = pathCount[7:0];
					IDX_SYNC_HI: st_next.rdata[7:0] = syncCount[15:8];
					IDX_SYNC_LO: st_next.rdata[7:0] = syncCount[7:0];
					IDX_FAR_HI: st_next.rdata[7:0] = farCount[15:8];
					IDX_FAR_LO: st_next.rdata[7:0] = farCount[7:0];
					IDX_MONITOR: st_next.rdata[7:0] = st_reg.monByte;
					IDX_FW_REV: st_next.rdata[7:0] = e1Mode ? FW_REV : 8'h00;
					IDX_LINK: st_next.rdata[7:0] = e1Mode
						? {searchCount[5:2], searchCount[0], crcMfSearching,
							signalingMfSearching, frameAlignSearching}
						: st_reg.rxLinkByte;
					IDX_CODE: st_next.rdata[7:0] = {2'b00, st_reg.rxCodeWord};
					IDX_SLC1: st_next.rdata[7:0] = e1Mode ? st_reg.align : st_reg.slc[7:0];
					IDX_SLC2: st_next.rdata[7:0] = e1Mode ? 8'h00 : st_reg.slc[15:8];
					IDX_SLC3: st_next.rdata[7:0] = e1Mode ? 8'h00 : st_reg.slc[23:16];
					IDX_CFG: st_next.rdata[7:0] = st_reg.cfg;
					IDX_MON_SEL: st_next.rdata[7:0] = {3'b000, st_reg.monSel};
					IDX_CODE_CTRL: st_next.rdata[7:0] = {codeLogicReset, 1'b0,
						st_reg.filter[3:2], 1'b0, st_reg.filter[1:0], 1'b0};
					default: st_next.rdata = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			st_reg <= '0;
			st_reg.cfg <= CFG_RESET;
			st_reg.monSel <= MON_SEL_RESET;
			st_reg.filter <= FILTER_RESET;
		end
		else
			st_reg <= st_next;
	end

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstN);

	property p_sig_freeze;
		frameSyncLost |=> $stable(st_reg.sig);
	endproperty
	a_sig_freeze: assert property (p_sig_freeze)
		else $error("signaling changed out of sync");

	property p_sf_copy;
		sigValid && !frameSyncLost && !e1Mode && !esfMode && sigPos[0]
			|=> st_reg.sig[$past(sigPos[4:1])][5:4] == st_reg.sig[$past(sigPos[4:1])][7:6];
	endproperty
	a_sf_copy: assert property (p_sf_copy) else $error("C/D not copied from A/B");

	property p_line_inc;
		lineErrEvent && lineCount != 16'hFFFF |=> lineCount == $past(lineCount) + 16'h0001;
	endproperty
	a_line_inc: assert property (p_line_inc) else $error("line count missed event");

	property p_far_t1;
		!e1Mode |=> $stable(farCount);
	endproperty
	a_far_t1: assert property (p_far_t1) else $error("far count moved in T1");

	property p_monitor;
		slotValid && slotNumber == monitorChannelSelect |=> st_reg.monByte == $past(slotByte);
	endproperty
	a_monitor: assert property (p_monitor) else $error("monitor byte not captured");

	property p_fw_read;
		rdSetup && idx == IDX_FW_REV && e1Mode |=> prdata == {24'h000000, FW_REV};
	endproperty
	a_fw_read: assert property (p_fw_read) else $error("wrong firmware revision");

	property p_search_zero_write;
		wrAccess && idx == IDX_CFG && !pwdata[CFG_CRC_BIT] |=> searchCount == 6'h00;
	endproperty
	a_search_zero_write: assert property (p_search_zero_write)
		else $error("search count kept");

	property p_ro_write;
		wrAccess && idx == IDX_LINE_HI && !lineErrEvent |=> $stable(lineCount);
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("host write altered counter");

	property p_code_reset_start;
		codeStart |=> codeLogicReset;
	endproperty
	a_code_reset_start: assert property (p_code_reset_start)
		else $error("code reset not begun");

	property p_search_sync_clear;
		crcSyncAchieved |=> searchCount == 6'h00;
	endproperty
	a_search_sync_clear: assert property (p_search_sync_clear)
		else $error("search count not cleared on sync");

	c_sync_loss: cover property (frameSyncLost && sigValid);
	c_link_sf: cover property (!esfMode && mfBoundary && !e1Mode);
	c_search_sat: cover property (searchCount == 6'h3F);
endmodule

/* File: verification/frx_line_model.sv */
// Far-end line model driving received events into the register group
module frx_line_model
(
	input wire logic clk,
	output logic frameSyncLost,
	output logic sigValid,
	output logic [4:0] sigChannel,
	output logic [3:0] sigBits,
	output logic [5:0] pulse,
	output logic slotValid,
	output logic [4:0] slotNumber,
	output logic [7:0] slotByte,
	output logic linkBitValid,
	output logic linkBit,
	output logic mfBoundary,
	output logic [2:0] searching,
	output logic codeValid,
	output logic [5:0] codeWord,
	output logic slcValid,
	output logic [23:0] slcBits,
	output logic alignValid,
	output logic [7:0] alignByte
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		{frameSyncLost, sigValid, sigChannel, sigBits, pulse, slotValid, slotNumber} = '0;
		{slotByte, linkBitValid, linkBit, mfBoundary, searching, codeValid} = '0;
		{codeWord, slcValid, slcBits, alignValid, alignByte} = '0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Pulse lines: 0 line, 1 path, 2 sync loss, 3 far, 4 timeout, 5 sync found
	task automatic burst(input logic [5:0] m, input int n);
		repeat (n)
		begin
			pulse <= m;
			@(posedge clk);
		end
		pulse <= '0;
		@(posedge clk);
	endtask

	// One strobe of a field; data lines invert once released
	task automatic put(input int k, input logic [4:0] n, input logic [23:0] d);
		case (k)
			0: {slotValid, slotNumber, slotByte} <= {1'b1, n, d[7:0]};
			1: {codeValid, codeWord} <= {1'b1, d[5:0]};
			2: {slcValid, slcBits} <= {1'b1, d};
			3: {alignValid, alignByte} <= {1'b1, d[7:0]};
			default: {sigValid, sigChannel, sigBits} <= {1'b1, n, d[3:0]};
		endcase
		@(posedge clk);
		{slotValid, codeValid, slcValid, alignValid, sigValid} <= '0;
		{slotByte, codeWord, slcBits} <= ~{slotByte, codeWord, slcBits};
		{alignByte, sigBits} <= ~{alignByte, sigBits};
		@(posedge clk);
	endtask

	// Link bits, first received first; boundary strobe with the last one
	task automatic link(input logic [7:0] b, input int n, input logic mf);
		for (int i = 0; i < n; i++)
		begin
			{linkBitValid, linkBit} <= {1'b1, b[i]};
			mfBoundary <= mf && i == n - 1;
			@(posedge clk);
		end
		{linkBitValid, mfBoundary} <= '0;
		linkBit <= ~linkBit;
		@(posedge clk);
	endtask
endmodule

/* File: verification/test_frx_status_counters.sv */
// Self-checking bench for the receive status and counter register group
module test_frx_status_counters;
	timeunit 1ns;
	timeprecision 1ps;
	import frx_pkg::*;
	localparam int RST_CYC = 20;
	localparam logic [7:0] FW = 8'h5A; // Arbitrary revision value
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err;
	logic frameSyncLost, sigValid, slotValid, linkBitValid, linkBit, mfBoundary;
	logic codeValid, slcValid, alignValid, codeLogicReset;
	logic e1Mode, esfMode, crcModeEnable;
	logic [4:0] sigChannel, slotNumber, monitorChannelSelect;
	logic [3:0] sigBits, codeFilterSetting;
	logic [5:0] pulse, codeWord;
	logic [2:0] searching;
	logic [7:0] slotByte, alignByte;
	logic [23:0] slcBits;
	int errors = 0;
	int n_tests = 0;
	int k;

	frx_status_counters #(.CODE_RESET_CNT(RST_CYC), .FW_REV(FW)) u_dut
	(
		.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.frameSyncLost, .sigValid, .sigChannel, .sigBits, .lineErrEvent(pulse[0]),
		.pathErrEvent(pulse[1]), .syncLossFrameEvent(pulse[2]), .farErrorEvent(pulse[3]),
		.slotValid, .slotNumber, .slotByte, .linkBitValid, .linkBit, .mfBoundary,
		.crcSearchTimeout(pulse[4]), .crcSyncAchieved(pulse[5]), .crcMfSearching(searching[2]),
		.signalingMfSearching(searching[1]), .frameAlignSearching(searching[0]),
		.codeValid, .codeWord, .slcValid, .slcBits, .alignValid, .alignByte, .e1Mode,
		.esfMode, .crcModeEnable, .monitorChannelSelect, .codeLogicReset, .codeFilterSetting
	);

	frx_line_model u_line
	(
		.clk, .frameSyncLost, .sigValid, .sigChannel, .sigBits, .pulse, .slotValid, .slotNumber,
		.slotByte, .linkBitValid, .linkBit, .mfBoundary, .searching, .codeValid, .codeWord,
		.slcValid, .slcBits, .alignValid, .alignByte
	);

	always #2.5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////
	task automatic test_done();
		if (errors == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// APB transfer; held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		int w;
		w = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1 && ++w < 64);
		if (w >= 64)
			chk(32'h0, 32'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(rd, {24'h0, exp});
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 8; i++)
			rdChk(8'(IDX_LINE_HI + i), 8'h00);
		apb(1'b1, IDX_CFG, 8'h02);
		u_line.burst(6'h01, 300);
		u_line.burst(6'h02, 5);
		u_line.burst(6'h04, 257);
		u_line.burst(6'h08, 4);
		apb(1'b1, IDX_LINE_HI, 8'hFF);
		apb(1'b1, IDX_LINE_LO, 8'hFF);
		rdChk(IDX_LINE_HI, 8'h01);
		rdChk(IDX_LINE_LO, 8'h2C);
		rdChk(IDX_PATH_LO, 8'h05);
		rdChk(IDX_SYNC_HI, 8'h01);
		rdChk(IDX_SYNC_LO, 8'h01);
		rdChk(IDX_FAR_LO, 8'h00);
		apb(1'b0, 8'h58, 8'h00);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, IDX_MON_SEL, 8'h05);
		@(posedge clk);
		chk({27'h0, monitorChannelSelect}, 32'h5);
		u_line.put(0, 5'd5, 24'hA5);
		u_line.put(0, 5'd6, 24'h3C);
		rdChk(IDX_MONITOR, 8'hA5);
		u_line.put(1, 5'd0, 24'hEA);
		rdChk(IDX_CODE, 8'h2A);
		u_line.link(8'hB4, 8, 1'b0);
		rdChk(IDX_LINK, 8'hB4);
		u_line.put(2, 5'd0, 24'h563412);
		rdChk(IDX_SLC1, 8'h12);
		rdChk(IDX_SLC2, 8'h34);
		rdChk(IDX_SLC3, 8'h56);
		u_line.put(4, 5'd13, 24'h6);
		rdChk(IDX_SIG_FIRST, 8'h06);
		apb(1'b1, IDX_CFG, 8'h00);
		u_line.put(4, 5'd1, 24'h8);
		rdChk(IDX_SIG_FIRST, 8'hA6);
		u_line.frameSyncLost <= 1'b1;
		u_line.put(4, 5'd1, 24'h4);
		rdChk(IDX_SIG_FIRST, 8'hA6);
		u_line.frameSyncLost <= 1'b0;
		u_line.link(8'h2D, 6, 1'b1);
		apb(1'b0, IDX_LINK, 8'h00);
		chk({26'h0, rd[5:0]}, 32'h2D);
		// Code reset with new filter settings pending
		apb(1'b1, IDX_CODE_CTRL, 8'hA4);
		apb(1'b0, IDX_CODE_CTRL, 8'h00);
		chk({31'h0, rd[7]}, 32'h1);
		chk({28'h0, codeFilterSetting}, 32'h0);
		k = 0;
		while (codeLogicReset !== 1'b0 && k < 3 * RST_CYC)
		begin
			@(posedge clk);
			k++;
		end
		chk({31'h0, k <= RST_CYC}, 32'h1);
		chk({28'h0, codeFilterSetting}, 32'hA);
		rdChk(IDX_CODE, 8'h00);
		apb(1'b1, IDX_CFG, 8'h09);
		@(posedge clk);
		chk({29'h0, e1Mode, esfMode, crcModeEnable}, 32'h5);
		u_line.put(4, 5'd16, 24'h3);
		rdChk(8'h41, 8'h03);
		rdChk(IDX_FW_REV, FW);
		for (int i = 0; i < 3; i++)
		begin
			u_line.searching <= 3'(1 << i);
			rdChk(IDX_LINK, 8'(1 << i));
		end
		u_line.searching <= 3'h0;
		u_line.burst(6'h10, 5);
		rdChk(IDX_LINK, 8'h18);
		u_line.burst(6'h10, 70);
		rdChk(IDX_LINK, 8'hF8);
		u_line.burst(6'h20, 1);
		rdChk(IDX_LINK, 8'h00);
		u_line.burst(6'h10, 3);
		rdChk(IDX_LINK, 8'h08);
		apb(1'b1, IDX_CFG, 8'h01);
		rdChk(IDX_LINK, 8'h00);
		u_line.put(3, 5'd0, 24'h9B);
		rdChk(IDX_SLC1, 8'h9B);
		u_line.burst(6'h08, 2);
		rdChk(IDX_FAR_LO, 8'h02);
		test_done();
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		errors++;
		test_done();
	end
endmodule
